// >>> clkbuf_pkg.sv
// constants for the per-output synchronous enable gating
// assumes: one reference clock, enable pins sampled on its falling edge
`default_nettype none

package clkbuf_pkg;

    // number of differential outputs on the larger variant
    localparam int NUM_OUT_DEF = 4;

    // reference clock: 25 MHz, period in ns
    localparam int REF_PERIOD_NS = 40;

    // stages of the enable pin synchroniser
    localparam int SYNC_STAGES = 2;

    // sample to output latency, in half reference cycles (3.5 and 4.5)
    localparam int ON_LAT_HALF = 7;
    localparam int OFF_LAT_HALF = 9;

    // falling edges spent in the going state before the gate changes
    localparam int ON_WAIT = (ON_LAT_HALF - 1) / 2 - SYNC_STAGES;
    localparam int OFF_WAIT = (OFF_LAT_HALF - 1) / 2 - SYNC_STAGES;

    // reference cycles received before any output may turn on
    localparam int WARMUP_CYC = 4;

    localparam int CNT_W = 3;

    // reset values
    localparam logic PIN_RST = 1'h1;
    localparam logic GATE_RST = 1'h0;

    typedef enum logic [1:0] {
        GATE_OFF,
        GATE_GOING_ON,
        GATE_ON,
        GATE_GOING_OFF
    } gate_state_t;

endpackage : clkbuf_pkg

`default_nettype wire

// >>> out_gate_cell.sv
// one output: enable delay state machine and glitch-free clock gate
// assumes: pin_low_req already synchronised on the falling edge
`default_nettype none

module out_gate_cell (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pin_low_req,
    input wire logic warm,
    output logic gate_on,
    output logic clk_pos,
    output logic clk_neg
);

    clkbuf_pkg::gate_state_t state_r;
    clkbuf_pkg::gate_state_t state_nxt;
    logic [clkbuf_pkg::CNT_W-1:0] cnt_r;
    logic [clkbuf_pkg::CNT_W-1:0] cnt_nxt;
    logic gate_r;
    logic gate_nxt;
    logic neg_gate_r;
    logic neg_gate_nxt;

    localparam logic [clkbuf_pkg::CNT_W-1:0] CNT_W1 =
        clkbuf_pkg::CNT_W'(1);
    localparam logic [clkbuf_pkg::CNT_W-1:0] CNT_ON =
        clkbuf_pkg::CNT_W'(clkbuf_pkg::ON_WAIT);
    localparam logic [clkbuf_pkg::CNT_W-1:0] CNT_OFF =
        clkbuf_pkg::CNT_W'(clkbuf_pkg::OFF_WAIT);

    ////////////////////////////////////////////////////////////////////////
    // enable / disable sequencing, falling-edge domain
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        gate_nxt = gate_r;
        case (state_r)
            clkbuf_pkg::GATE_OFF: begin
                gate_nxt = 1'h0;
                cnt_nxt = '0;
                if (pin_low_req && warm) begin
                    state_nxt = clkbuf_pkg::GATE_GOING_ON;
                    cnt_nxt = CNT_W1;
                end
            end
            clkbuf_pkg::GATE_GOING_ON: begin
                if (!pin_low_req) begin
                    state_nxt = clkbuf_pkg::GATE_OFF;
                end else if (cnt_r >= CNT_ON) begin
                    state_nxt = clkbuf_pkg::GATE_ON;
                    gate_nxt = 1'h1;
                end else begin
                    cnt_nxt = cnt_r + CNT_W1;
                end
            end
            clkbuf_pkg::GATE_ON: begin
                gate_nxt = 1'h1;
                cnt_nxt = '0;
                if (!pin_low_req) begin
                    state_nxt = clkbuf_pkg::GATE_GOING_OFF;
                    cnt_nxt = CNT_W1;
                end
            end
            clkbuf_pkg::GATE_GOING_OFF: begin
                if (pin_low_req) begin
                    state_nxt = clkbuf_pkg::GATE_ON;
                end else if (cnt_r >= CNT_OFF) begin
                    state_nxt = clkbuf_pkg::GATE_OFF;
                    gate_nxt = 1'h0;
                end else begin
                    cnt_nxt = cnt_r + CNT_W1;
                end
            end
            default: begin
                state_nxt = clkbuf_pkg::GATE_OFF;
                cnt_nxt = '0;
                gate_nxt = 1'h0;
            end
        endcase
    end

    // gate changes only while the reference is low
    always_ff @(negedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= clkbuf_pkg::GATE_OFF;
            cnt_r <= '0;
            gate_r <= clkbuf_pkg::GATE_RST;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            gate_r <= gate_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // negative leg gate follows half a cycle later, while it is low
    always_comb begin
        neg_gate_nxt = gate_r;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            neg_gate_r <= clkbuf_pkg::GATE_RST;
        end else begin
            neg_gate_r <= neg_gate_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // gated copy of the reference, both legs low when off
    always_comb begin
        gate_on = gate_r;
        clk_pos = ref_clk & gate_r;
        clk_neg = ~ref_clk & neg_gate_r;
    end

endmodule : out_gate_cell

`default_nettype wire

// >>> sync_output_enable_gating.sv
// per-output synchronous enable gating for a fan-out clock buffer
// assumes: ref_clk is the reference input, enable pins come from the board
//
// Overview of operation
// - output active while its enable pin low
// - each output has its own independent enable
// - enable pins sampled on reference falling edge
// - output starts 3.5 cycles after low sampled
// - output stops 4.5 cycles after high sampled
// - gating in step with clock, no runts
// - undriven enable pin reads low, output enabled
// - outputs held off for four cycles after power-up
`default_nettype none

module sync_output_enable_gating #(
    parameter int NUM_OUT = clkbuf_pkg::NUM_OUT_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [NUM_OUT-1:0] out_enable_n,
    output logic [NUM_OUT-1:0] clk_out_pos,
    output logic [NUM_OUT-1:0] clk_out_neg,
    output logic [NUM_OUT-1:0] out_active
);

    localparam logic [clkbuf_pkg::CNT_W-1:0] WARM_MAX =
        clkbuf_pkg::CNT_W'(clkbuf_pkg::WARMUP_CYC);
    localparam logic [clkbuf_pkg::CNT_W-1:0] WARM_ONE =
        clkbuf_pkg::CNT_W'(1);

    logic [NUM_OUT-1:0] pin_meta_r;
    logic [NUM_OUT-1:0] pin_sync_r;
    logic [clkbuf_pkg::CNT_W-1:0] warm_cnt_r;
    logic [clkbuf_pkg::CNT_W-1:0] warm_cnt_nxt;
    logic warm_r;
    logic warm_nxt;

    ////////////////////////////////////////////////////////////////////////
    // power-up hold: count received reference cycles
    always_comb begin
        warm_cnt_nxt = warm_cnt_r;
        warm_nxt = warm_r;
        if (warm_cnt_r < WARM_MAX) begin
            warm_cnt_nxt = warm_cnt_r + WARM_ONE;
        end else begin
            warm_nxt = 1'h1;
        end
    end

    always_ff @(negedge ref_clk or posedge rst) begin
        if (rst) begin
            warm_cnt_r <= '0;
            warm_r <= 1'b0;
        end else begin
            warm_cnt_r <= warm_cnt_nxt;
            warm_r <= warm_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enable pin synchroniser on the falling edge
    always_ff @(negedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_meta_r <= {NUM_OUT{clkbuf_pkg::PIN_RST}};
            pin_sync_r <= {NUM_OUT{clkbuf_pkg::PIN_RST}};
        end else begin
            pin_meta_r <= out_enable_n;
            pin_sync_r <= pin_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one independent gate per output
    for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
        out_gate_cell u_cell (
            .ref_clk(ref_clk),
            .rst(rst),
            .pin_low_req(~pin_sync_r[i]),
            .warm(warm_r),
            .gate_on(out_active[i]),
            .clk_pos(clk_out_pos[i]),
            .clk_neg(clk_out_neg[i])
        );
    end

endmodule : sync_output_enable_gating

`default_nettype wire

// >>> board_enable_model.sv
// board side: enable pin drivers
// assumes: undriven pin falls to pull-down
`default_nettype none
module board_enable_model #(
    parameter int NUM_OUT = 4
) (
    input wire logic [NUM_OUT-1:0] drive_en,
    input wire logic [NUM_OUT-1:0] level,
    output logic [NUM_OUT-1:0] out_enable_n
);
    timeunit 1ns;
    timeprecision 1ns;
    assign out_enable_n = drive_en & level;
endmodule : board_enable_model
`default_nettype wire

// >>> sync_output_enable_gating_props.sv
// checker for the gating top
// assumes: bound to every instance
`default_nettype none
module sync_output_enable_gating_props #(
    parameter int NUM_OUT = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [NUM_OUT-1:0] out_enable_n,
    input wire logic [NUM_OUT-1:0] clk_out_pos,
    input wire logic [NUM_OUT-1:0] clk_out_neg,
    input wire logic [NUM_OUT-1:0] out_active
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] edges_r;
    always_ff @(negedge ref_clk or posedge rst) begin
        if (rst) edges_r <= 4'h0;
        else if (edges_r != 4'hF) edges_r <= edges_r + 4'h1;
    end
    default clocking @(negedge ref_clk); endclocking
    default disable iff (rst);
    AST_ON: assert property (
        (edges_r == 4'hF && !out_enable_n[0]) [*4] |=> out_active[0])
        else $error("output 0 not on");
    AST_OFF: assert property (out_enable_n[0] [*5]
        |=> !out_active[0]) else $error("output 0 not off");
    AST_ROSE: assert property ($rose(out_active[0])
        |-> !$past(out_enable_n[0], 4)) else $error("early on");
    AST_FELL: assert property ($fell(out_active[0])
        |-> $past(out_enable_n[0], 5)) else $error("early off");
    AST_POS: assert property (clk_out_pos == out_active)
        else $error("pos leg wrong");
    AST_NEG: assert property (@(posedge ref_clk)
        clk_out_neg == $past(out_active)) else $error("neg leg wrong");
    AST_WARM: assert property (edges_r < 4'h4 |-> out_active == '0)
        else $error("on before warm-up");
    AST_INDEP: assert property ((edges_r == 4'hF &&
        $stable(out_enable_n[1])) [*6] |-> $stable(out_active[1]))
        else $error("output 1 disturbed");
endmodule : sync_output_enable_gating_props
bind sync_output_enable_gating sync_output_enable_gating_props #(
    .NUM_OUT(NUM_OUT)) u_props (.ref_clk(ref_clk), .rst(rst),
    .out_enable_n(out_enable_n), .clk_out_pos(clk_out_pos),
    .clk_out_neg(clk_out_neg), .out_active(out_active));
`default_nettype wire

// >>> test_sync_output_enable_gating.sv
// testbench: row table, then latency, cancel and warm-up
// assumes: four outputs, board model on the pins
`default_nettype none
module test_sync_output_enable_gating;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic [3:0] drv = 4'h0;
    logic [3:0] lvl = 4'h0;
    wire logic [3:0] pin_n, pos, neg, act;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [11:0] rows [5] = '{12'hF0F, 12'hF1E, 12'hFA5, 12'h00F, 12'hFF0};
    board_enable_model u_board_enable_model (.drive_en(drv), .level(lvl),
        .out_enable_n(pin_n));
    sync_output_enable_gating u_sync_output_enable_gating (.ref_clk(ref_clk),
        .rst(rst), .out_enable_n(pin_n), .clk_out_pos(pos),
        .clk_out_neg(neg), .out_active(act));
    always #(clkbuf_pkg::REF_PERIOD_NS / 2) ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 3000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("Error %0t: got %h exp %h", $time, got, exp);
            miscompares++;
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : step
    task automatic lat(input logic [3:0] l, input int n, input logic [3:0] b);
        step(1);
        lvl = l;
        repeat (n) @(negedge ref_clk);
        #1 chk(act, b);
        @(negedge ref_clk);
        #1 chk(act, b ^ 4'h1);
    endtask : lat
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    initial begin
        step(6);
        chk(pos | neg | act, 4'h0);
        rst = 1'h0;
        step(4);
        chk(act, 4'h0);
        foreach (rows[i]) begin
            {drv, lvl} = rows[i][11:4];
            step(6);
            #(clkbuf_pkg::REF_PERIOD_NS / 2);
            chk(neg, rows[i][3:0]);
            step(1);
            chk(act, rows[i][3:0]);
            chk(pos, rows[i][3:0]);
        end
        lat(4'hE, 3, 4'h0);
        lat(4'hF, 4, 4'h1);
        step(1);
        lvl = 4'hE;
        step(1);
        lvl = 4'hF;
        step(3);
        chk(act, 4'h0);
        step(5);
        chk(act, 4'h0);
        lvl = 4'h0;
        step(8);
        chk(act, 4'hF);
        lvl = 4'h1;
        step(1);
        lvl = 4'h0;
        step(3);
        chk(act, 4'hF);
        step(5);
        chk(act, 4'hF);
        rst = 1'h1;
        step(2);
        chk(pos | neg | act, 4'h0);
        rst = 1'h0;
        step(4);
        chk(act, 4'h0);
        step(4);
        chk(act, 4'hF);
        end_of_test();
    end
endmodule : test_sync_output_enable_gating
`default_nettype wire
